// File: hdl/i2c_master_engine.sv
// two-wire master engine: receive, acknowledge, start, stop, transmit and arbitration
//
// Implementation choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`include "i2c_master_engine_map.svh"

module i2c_master_engine (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [2:0] regAddr,
  input  wire logic [7:0] regWdata,
  input  wire logic       regWr,
  input  wire logic       regRd,
  output logic      [7:0] regRdata,
  input  wire logic       sdaIn,
  output logic            sdaOut,
  output logic            sdaOe,
  input  wire logic       sclIn,
  output logic            sclOut,
  output logic            sclOe,
  output logic            serialIrq,
  output logic            busCollision
);

  i2c_master_engine_pkg::regs_type q;
  i2c_master_engine_pkg::regs_type d;

  logic sdaNow;
  logic sclNow;
  logic tick;
  logic rollover;
  logic engineIdle;
  logic busStart;
  logic busStop;
  logic bufWr;
  logic seqWr;
  logic statWr;

  assign sdaNow     = q.sdaS2;
  assign sclNow     = q.sclS2;
  assign tick       = (q.pre == `BAUD_PRESCALE);
  assign rollover   = tick && (q.baud == 8'h00);
  assign engineIdle = (q.st == i2c_master_engine_pkg::IDLE) && !q.startEn && !q.stopEn
                      && !q.receiveEn && !q.acknowledge_enable_bit;
  assign busStart   = q.sdaPrev && !sdaNow && q.sclPrev && sclNow;
  assign busStop    = !q.sdaPrev && sdaNow && q.sclPrev && sclNow;
  assign bufWr      = regWr && (regAddr == `ADDR_DATA_BUFFER);
  assign seqWr      = regWr && (regAddr == `ADDR_SEQ_CONTROL);
  assign statWr     = regWr && (regAddr == `ADDR_SERIAL_STATUS);

  always_comb begin
    d = q;
    // pins pass two flops before any logic looks at them
    d.sdaS1   = sdaIn;
    d.sdaS2   = q.sdaS1;
    d.sdaPrev = q.sdaS2;
    d.sclS1   = sclIn;
    d.sclS2   = q.sclS1;
    d.sclPrev = q.sclS2;

    // baud counter counts down and holds at zero; states reload it where a period starts
    d.pre = tick ? 2'h0 : q.pre + 2'h1;
    if (tick && q.baud != 8'h00) begin
      d.baud = q.baud - 8'h01;
    end

    // status flags: write one to clear, a set later in this process wins
    if (statWr) begin
      d.serialIrq = q.serialIrq & ~regWdata[`STAT_SERIAL_IRQ];
      d.busColl   = q.busColl & ~regWdata[`STAT_BUS_COLLISION];
      d.overflow  = q.overflow & ~regWdata[`STAT_OVERFLOW];
      d.writeColl = q.writeColl & ~regWdata[`STAT_WRITE_COLL];
    end
    if (regWr && regAddr == `ADDR_BAUD_DIVISOR) begin
      d.divisor = regWdata;
    end
    if (regWr && regAddr == `ADDR_ENGINE_CONTROL) begin
      d.enable = regWdata[`CTRL_ENABLE_BIT];
    end
    if (seqWr) begin
      d.ackData = regWdata[`SEQ_ACK_DATA_BIT];
    end
    if (regRd && regAddr == `ADDR_DATA_BUFFER) begin
      d.bufferFull = 1'b0;
    end

    // bus monitor for multi-master free detection
    if (busStart) begin
      d.startDet = 1'b1;
      d.stopDet  = 1'b0;
    end
    if (busStop) begin
      d.stopDet  = 1'b1;
      d.startDet = 1'b0;
      if (q.st == i2c_master_engine_pkg::IDLE && q.enable) begin
        d.serialIrq = 1'b1;
      end
    end

    // commands are taken only when idle, no queuing
    if (q.enable && engineIdle) begin
      if (seqWr && regWdata[`SEQ_START_BIT]) begin
        d.startEn = 1'b1;
        d.st      = i2c_master_engine_pkg::START_CHK;
      end else if (seqWr && regWdata[`SEQ_STOP_BIT]) begin
        d.stopEn = 1'b1;
        d.sdaLow = 1'b1;
        d.sclLow = 1'b1;
        d.st     = i2c_master_engine_pkg::STOP_SDA;
      end else if (seqWr && regWdata[`SEQ_RECEIVE_BIT]) begin
        d.receiveEn = 1'b1;
        d.mode      = i2c_master_engine_pkg::MODE_RX;
        d.bitCnt    = 4'h0;
        d.sdaLow    = 1'b0;
        d.sclLow    = 1'b1;
        d.baud      = q.divisor;
        d.pre       = 2'h0;
        d.st        = i2c_master_engine_pkg::BIT_LOW;
      end else if (seqWr && regWdata[`SEQ_ACK_ENABLE_BIT]) begin
        d.acknowledge_enable_bit  = 1'b1;
        d.mode   = i2c_master_engine_pkg::MODE_ACK;
        d.sdaLow = !regWdata[`SEQ_ACK_DATA_BIT];
        d.sclLow = 1'b1;
        d.baud   = q.divisor;
        d.pre    = 2'h0;
        d.st     = i2c_master_engine_pkg::BIT_LOW;
      end else if (bufWr) begin
        // always from the top bit, whatever an earlier transfer left behind
        d.buffer     = regWdata;
        d.shift      = regWdata;
        d.bufferFull = 1'b1;
        d.mode       = i2c_master_engine_pkg::MODE_TX;
        d.bitCnt     = 4'h0;
        d.sdaLow     = !regWdata[7];
        d.sclLow     = 1'b1;
        d.baud       = q.divisor;
        d.pre        = 2'h0;
        d.st         = i2c_master_engine_pkg::BIT_LOW;
      end
    end else if (bufWr) begin
      d.writeColl = 1'b1;
    end

    case (q.st)
      i2c_master_engine_pkg::IDLE: begin
      end
      i2c_master_engine_pkg::START_CHK: begin
        if (!sdaNow || !sclNow) begin
          d.busColl = 1'b1;
          d.startEn = 1'b0;
          d.st      = i2c_master_engine_pkg::IDLE;
        end else begin
          d.baud = q.divisor;
          d.pre  = 2'h0;
          d.st   = i2c_master_engine_pkg::START_CNT;
        end
      end
      i2c_master_engine_pkg::START_CNT: begin
        if (!sclNow && sdaNow) begin
          d.busColl = 1'b1;
          d.startEn = 1'b0;
          d.st      = i2c_master_engine_pkg::IDLE;
        end else if (!sdaNow || rollover) begin
          // another master went first: follow at once and arbitrate later
          d.sdaLow = 1'b1;
          d.baud   = q.divisor;
          d.pre    = 2'h0;
          d.st     = i2c_master_engine_pkg::START_HOLD;
        end
      end
      i2c_master_engine_pkg::START_HOLD: begin
        if (rollover) begin
          d.sclLow    = 1'b1;
          d.startEn   = 1'b0;
          d.serialIrq = 1'b1;
          d.st        = i2c_master_engine_pkg::IDLE;
        end
      end
      i2c_master_engine_pkg::BIT_LOW: begin
        if (rollover) begin
          d.sclLow = 1'b0;
          d.st     = i2c_master_engine_pkg::BIT_WAIT;
        end
      end
      i2c_master_engine_pkg::BIT_WAIT: begin
        if (sclNow) begin
          d.baud = q.divisor;
          d.pre  = 2'h0;
          d.st   = i2c_master_engine_pkg::BIT_HIGH;
        end
      end
      i2c_master_engine_pkg::BIT_HIGH: begin
        if (!q.sdaLow && !sdaNow && q.mode != i2c_master_engine_pkg::MODE_RX
            && !(q.mode == i2c_master_engine_pkg::MODE_TX && q.bitCnt == `ACK_BIT_INDEX)) begin
          d.busColl = 1'b1;
          d.sdaLow  = 1'b0;
          d.sclLow  = 1'b0;
          d.acknowledge_enable_bit   = 1'b0;
          if (q.mode == i2c_master_engine_pkg::MODE_TX) begin
            d.bufferFull = 1'b0;
          end
          d.st = i2c_master_engine_pkg::IDLE;
        end else if (rollover) begin
          d.sclLow = 1'b1;
          d.baud   = q.divisor;
          d.pre    = 2'h0;
          d.bitCnt = q.bitCnt + 4'h1;
          d.st     = i2c_master_engine_pkg::BIT_LOW;
          case (q.mode)
            i2c_master_engine_pkg::MODE_RX: begin
              d.shift = {q.shift[6:0], sdaNow};
              if (q.bitCnt == `LAST_DATA_BIT) begin
                d.buffer    = {q.shift[6:0], sdaNow};
                d.bufferFull = 1'b1;
                d.overflow  = q.overflow | q.bufferFull;
                d.serialIrq = 1'b1;
                d.receiveEn = 1'b0;
                d.st        = i2c_master_engine_pkg::IDLE;
              end
            end
            i2c_master_engine_pkg::MODE_ACK: begin
              d.acknowledge_enable_bit = 1'b0;
              d.st    = i2c_master_engine_pkg::IDLE;
            end
            default: begin
              if (q.bitCnt == `ACK_BIT_INDEX) begin
                d.ackStatus = sdaNow;
                d.serialIrq = 1'b1;
                d.st        = i2c_master_engine_pkg::IDLE;
              end else if (q.bitCnt == `LAST_DATA_BIT) begin
                d.bufferFull = 1'b0;
                d.sdaLow     = 1'b0;
              end else begin
                d.shift  = {q.shift[6:0], 1'b0};
                d.sdaLow = !q.shift[6];
              end
            end
          endcase
        end
      end
      i2c_master_engine_pkg::STOP_SDA: begin
        if (!sdaNow) begin
          d.baud = q.divisor;
          d.pre  = 2'h0;
          d.st   = i2c_master_engine_pkg::STOP_CNT;
        end
      end
      i2c_master_engine_pkg::STOP_CNT: begin
        if (rollover) begin
          d.sclLow = 1'b0;
          d.st     = i2c_master_engine_pkg::STOP_WAIT;
        end
      end
      i2c_master_engine_pkg::STOP_WAIT: begin
        if (sclNow) begin
          d.baud = q.divisor;
          d.pre  = 2'h0;
          d.st   = i2c_master_engine_pkg::STOP_HIGH;
        end
      end
      i2c_master_engine_pkg::STOP_HIGH: begin
        if (!sclNow) begin
          d.busColl = 1'b1;
          d.sdaLow  = 1'b0;
          d.stopEn  = 1'b0;
          d.st      = i2c_master_engine_pkg::IDLE;
        end else if (rollover) begin
          d.sdaLow = 1'b0;
          d.st     = i2c_master_engine_pkg::STOP_REL;
        end
      end
      i2c_master_engine_pkg::STOP_REL: begin
        if (sdaNow && sclNow) begin
          d.baud = q.divisor;
          d.pre  = 2'h0;
          d.st   = i2c_master_engine_pkg::STOP_END;
        end
      end
      i2c_master_engine_pkg::STOP_END: begin
        if (rollover) begin
          d.stopEn    = 1'b0;
          d.serialIrq = 1'b1;
          d.st        = i2c_master_engine_pkg::IDLE;
        end
      end
      default: begin
        d.st = i2c_master_engine_pkg::IDLE;
      end
    endcase

    // disabled engine lets go of the bus and forgets bus state
    if (!q.enable) begin
      d.st        = i2c_master_engine_pkg::IDLE;
      d.startEn   = 1'b0;
      d.stopEn    = 1'b0;
      d.receiveEn = 1'b0;
      d.acknowledge_enable_bit     = 1'b0;
      d.sdaLow    = 1'b0;
      d.sclLow    = 1'b0;
      d.startDet  = 1'b0;
      d.stopDet   = 1'b0;
    end

    // read data stands for one cycle only
    d.rdata = 8'h00;
    if (regRd) begin
      case (regAddr)
        `ADDR_DATA_BUFFER:    d.rdata = q.buffer;
        `ADDR_SEQ_CONTROL:    d.rdata = {2'h0, q.ackStatus, q.ackData, q.acknowledge_enable_bit,
                                         q.receiveEn, q.stopEn, q.startEn};
        `ADDR_SERIAL_STATUS:  d.rdata = {1'b0, q.writeColl, q.overflow, q.busColl,
                                         q.serialIrq, q.stopDet, q.startDet, q.bufferFull};
        `ADDR_BAUD_DIVISOR:   d.rdata = q.divisor;
        `ADDR_ENGINE_CONTROL: d.rdata = {7'h00, q.enable};
        default:              d.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q         <= '0;
      q.st      <= i2c_master_engine_pkg::IDLE;
      q.mode    <= i2c_master_engine_pkg::MODE_TX;
      q.divisor <= `BAUD_DIVISOR_RESET;
      q.sdaS1   <= 1'b1;
      q.sdaS2   <= 1'b1;
      q.sdaPrev <= 1'b1;
      q.sclS1   <= 1'b1;
      q.sclS2   <= 1'b1;
      q.sclPrev <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // pins are open drain: output value is always low, only the enable moves
  assign regRdata     = q.rdata;
  assign sdaOut       = 1'b0;
  assign sclOut       = 1'b0;
  assign sdaOe        = q.sdaLow;
  assign sclOe        = q.sclLow;
  assign serialIrq    = q.serialIrq;
  assign busCollision = q.busColl;

endmodule // i2c_master_engine

// File: hdl/i2c_master_engine_map.svh
// register offsets, field positions, reset values and timing figures of the serial engine
`ifndef I2C_MASTER_ENGINE_MAP_SVH
`define I2C_MASTER_ENGINE_MAP_SVH

`define ADDR_DATA_BUFFER    3'h0
`define ADDR_SEQ_CONTROL    3'h1
`define ADDR_SERIAL_STATUS  3'h2
`define ADDR_BAUD_DIVISOR   3'h3
`define ADDR_ENGINE_CONTROL 3'h4

`define SEQ_START_BIT       0
`define SEQ_STOP_BIT        1
`define SEQ_RECEIVE_BIT     2
`define SEQ_ACK_ENABLE_BIT  3
`define SEQ_ACK_DATA_BIT    4
`define SEQ_ACK_STATUS_BIT  5

`define STAT_BUFFER_FULL    0
`define STAT_START_DET      1
`define STAT_STOP_DET       2
`define STAT_SERIAL_IRQ     3
`define STAT_BUS_COLLISION  4
`define STAT_OVERFLOW       5
`define STAT_WRITE_COLL     6

`define CTRL_ENABLE_BIT     0

`define BAUD_DIVISOR_RESET  8'h13
`define BAUD_PRESCALE       2'h1
`define LAST_DATA_BIT       4'h7
`define ACK_BIT_INDEX       4'h8

`endif

// File: hdl/i2c_master_engine_pkg.sv
// types of the serial engine
package i2c_master_engine_pkg;

  typedef enum logic [3:0] {
    IDLE       = 4'b0000,
    START_CHK  = 4'b0001,
    START_CNT  = 4'b0010,
    START_HOLD = 4'b0011,
    BIT_LOW    = 4'b0100,
    BIT_WAIT   = 4'b0101,
    BIT_HIGH   = 4'b0110,
    STOP_SDA   = 4'b0111,
    STOP_CNT   = 4'b1000,
    STOP_WAIT  = 4'b1001,
    STOP_HIGH  = 4'b1010,
    STOP_REL   = 4'b1011,
    STOP_END   = 4'b1100
  } state_type;

  typedef enum logic [1:0] {
    MODE_TX  = 2'b00,
    MODE_RX  = 2'b01,
    MODE_ACK = 2'b10
  } mode_type;

  typedef struct packed {
    state_type  st;
    mode_type   mode;
    logic [7:0] baud;
    logic [1:0] pre;
    logic [3:0] bitCnt;
    logic [7:0] shift;
    logic [7:0] buffer;
    logic [7:0] divisor;
    logic       enable;
    logic       startEn;
    logic       stopEn;
    logic       receiveEn;
    logic       acknowledge_enable_bit;
    logic       ackData;
    logic       ackStatus;
    logic       bufferFull;
    logic       writeColl;
    logic       overflow;
    logic       serialIrq;
    logic       busColl;
    logic       startDet;
    logic       stopDet;
    logic       sdaLow;
    logic       sclLow;
    logic       sdaS1;
    logic       sdaS2;
    logic       sdaPrev;
    logic       sclS1;
    logic       sclS2;
    logic       sclPrev;
    logic [7:0] rdata;
  } regs_type;

endpackage

// File: verif/i2c_master_engine_sva.sv
// port assertions of the serial engine
`timescale 1ns/1ps
`include "i2c_master_engine_map.svh"
module i2c_master_engine_sva (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic [2:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic       regWr,
  input wire logic       regRd,
  input wire logic [7:0] regRdata,
  input wire logic       sdaIn,
  input wire logic       sdaOut,
  input wire logic       sdaOe,
  input wire logic       sclIn,
  input wire logic       sclOut,
  input wire logic       sclOe,
  input wire logic       serialIrq,
  input wire logic       busCollision
);
  logic irqClr;
  logic collClr;
  logic stWr;

  // only a write-one-to-clear drops these flags; disabling keeps them
  assign stWr    = regWr && regAddr == `ADDR_SERIAL_STATUS;
  assign irqClr  = stWr && regWdata[`STAT_SERIAL_IRQ];
  assign collClr = stWr && regWdata[`STAT_BUS_COLLISION];

  chk_reset_quiet: assert property (@(posedge clk)
    rst |=> !sdaOe && !sclOe && !serialIrq && !busCollision && regRdata == 8'h00)
    else $error("outputs active after reset");
  chk_pins_low: assert property (@(posedge clk)
    sdaOut == 1'b0 && sclOut == 1'b0) else $error("pin driven high");
  chk_rdata_slot: assert property (@(posedge clk) disable iff (rst)
    !$past(regRd) |-> regRdata == 8'h00) else $error("read data outside its slot");
  chk_coll_release: assert property (@(posedge clk) disable iff (rst)
    $rose(busCollision) |-> ##[0:2] (!sdaOe && !sclOe)) else $error("lines held after collision");
  chk_scl_high_first: assert property (@(posedge clk) disable iff (rst)
    $rose(sclOe) |-> $past(sclIn, 3) && $past(sclIn, 4)) else $error("clock pulled while low");
  chk_stop_order: assert property (@(posedge clk) disable iff (rst)
    $fell(sdaOe) && !sclOe |-> !$past(sclOe, 4) && !$past(sclOe, 8))
    else $error("data released too soon after clock");
  chk_irq_clear: assert property (@(posedge clk) disable iff (rst)
    $fell(serialIrq) |-> $past(irqClr) || $past(irqClr, 2)) else $error("irq dropped by itself");
  chk_coll_clear: assert property (@(posedge clk) disable iff (rst)
    $fell(busCollision) |-> $past(collClr) || $past(collClr, 2))
    else $error("collision flag dropped by itself");
endmodule // i2c_master_engine_sva

bind i2c_master_engine i2c_master_engine_sva chk (.clk(clk), .rst(rst), .regAddr(regAddr),
  .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .sdaIn(sdaIn),
  .sdaOut(sdaOut), .sdaOe(sdaOe), .sclIn(sclIn), .sclOut(sclOut), .sclOe(sclOe),
  .serialIrq(serialIrq), .busCollision(busCollision));

// File: verif/i2c_slave_model.sv
// behavioural slave: sends one byte msb first, may stretch the clock
`timescale 1ns/1ps
module i2c_slave_model (
  input  wire logic       clk,
  input  wire logic       sclLine,
  input  wire logic [7:0] sendByte,
  input  wire logic       sendEn,
  input  wire logic       stretch,
  output logic            sdaPull,
  output logic            sclPull
);
  logic       sclPrev;
  logic       seenRise;
  logic [3:0] bitIdx;
  logic [4:0] holdCnt;

  initial begin
    sclPrev = 1'b1;
    seenRise = 1'b0;
    bitIdx = 4'h0;
    holdCnt = 5'h00;
  end

  // bits move only after a falling clock, so sda is steady while scl is high
  always @(posedge clk) begin
    sclPrev <= sclLine;
    if (!sendEn) begin
      bitIdx <= 4'h0;
      seenRise <= 1'b0;
    end else if (!sclPrev && sclLine) begin
      seenRise <= 1'b1;
    end else if (sclPrev && !sclLine && seenRise) begin
      bitIdx <= bitIdx + 4'h1;
      seenRise <= 1'b0;
    end
    if (sclPrev && !sclLine && stretch) begin
      holdCnt <= 5'h14;
    end else if (holdCnt != 5'h00) begin
      holdCnt <= holdCnt - 5'h01;
    end
  end

  // after the eighth bit sda goes back to its pull-up
  assign sdaPull = sendEn && bitIdx < 4'h8 && !sendByte[3'h7 - bitIdx[2:0]];
  assign sclPull = holdCnt != 5'h00;
endmodule // i2c_slave_model

// File: verif/i2c_master_rx_ack_stop_arbitration_test.sv
// testbench of the serial engine: receive, acknowledge, stop and collision
`timescale 1ns/1ps
`include "i2c_master_engine_map.svh"
module i2c_master_rx_ack_stop_arbitration_test;
  logic       clk, rst, regWr, regRd;
  logic [2:0] regAddr;
  logic [7:0] regWdata, regRdata, sendByte;
  logic       sdaOut, sdaOe, sclOut, sclOe, serialIrq, busCollision;
  logic       slaveSda, slaveScl, tbSda, sendEn, stretch, sdaLine, sclLine;
  int         mismatches, tests_run;

  assign sdaLine = !(sdaOe || slaveSda || tbSda);
  assign sclLine = !(sclOe || slaveScl);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  i2c_master_engine uut (.clk(clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .sdaIn(sdaLine), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .sclIn(sclLine), .sclOut(sclOut), .sclOe(sclOe), .serialIrq(serialIrq),
    .busCollision(busCollision));

  i2c_slave_model slave (.clk(clk), .sclLine(sclLine), .sendByte(sendByte), .sendEn(sendEn),
    .stretch(stretch), .sdaPull(slaveSda), .sclPull(slaveScl));

  task automatic wrap_up;
    if (mismatches == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1 d = regRdata;
  endtask

  task automatic check(input logic [2:0] a, input logic [7:0] mask, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    cmp(d & mask, exp);
  endtask

  task automatic pin(input logic v, input logic e);
    cmp({7'h00, v}, {7'h00, e});
  endtask

  // polls a bit with a bounded number of reads
  task automatic wait_bit(input logic [2:0] a, input int b, input logic v);
    logic [7:0] d;
    for (int n = 0; n < 400; n++) begin
      rd(a, d);
      if (d[b] === v) break;
    end
    pin(d[b], v);
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    wrap_up;
  end

  initial begin
    rst = 1'b1;
    regAddr = 3'h0;
    regWdata = 8'h00;
    regWr = 1'b0;
    regRd = 1'b0;
    tbSda = 1'b0;
    sendEn = 1'b0;
    stretch = 1'b0;
    sendByte = 8'hA5;
    mismatches = 0;
    tests_run = 0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    check(`ADDR_SERIAL_STATUS, 8'hFF, 8'h00);
    check(`ADDR_BAUD_DIVISOR, 8'hFF, `BAUD_DIVISOR_RESET);
    check(3'h5, 8'hFF, 8'h00);
    wr(`ADDR_SEQ_CONTROL, 8'h04);
    check(`ADDR_SEQ_CONTROL, 8'h04, 8'h00);
    wr(`ADDR_BAUD_DIVISOR, 8'h03);
    check(`ADDR_BAUD_DIVISOR, 8'hFF, 8'h03);
    wr(`ADDR_ENGINE_CONTROL, 8'h01);
    // first byte, with a buffer write landing mid-byte
    sendEn <= 1'b1;
    wr(`ADDR_SEQ_CONTROL, 8'h04);
    repeat (30) @(posedge clk);
    wr(`ADDR_DATA_BUFFER, 8'h5A);
    check(`ADDR_SERIAL_STATUS, 8'h40, 8'h40);
    wait_bit(`ADDR_SERIAL_STATUS, `STAT_SERIAL_IRQ, 1'b1);
    check(`ADDR_SERIAL_STATUS, 8'h21, 8'h01);
    check(`ADDR_SEQ_CONTROL, 8'h04, 8'h00);
    pin(sclOe, 1'b1);
    wr(`ADDR_SERIAL_STATUS, 8'h78);
    sendEn <= 1'b0;
    // acknowledge; a receive request and a buffer write arrive while it runs
    wr(`ADDR_SEQ_CONTROL, 8'h08);
    wr(`ADDR_SEQ_CONTROL, 8'h04);
    pin(sdaOe, 1'b1);
    wr(`ADDR_DATA_BUFFER, 8'h5A);
    check(`ADDR_SEQ_CONTROL, 8'h04, 8'h00);
    check(`ADDR_SERIAL_STATUS, 8'h40, 8'h40);
    wait_bit(`ADDR_SEQ_CONTROL, `SEQ_ACK_ENABLE_BIT, 1'b0);
    pin(sclOe, 1'b1);
    // second byte with clock stretching, first byte never read
    wr(`ADDR_SERIAL_STATUS, 8'h78);
    sendByte <= 8'h3C;
    stretch <= 1'b1;
    sendEn <= 1'b1;
    wr(`ADDR_SEQ_CONTROL, 8'h04);
    wait_bit(`ADDR_SERIAL_STATUS, `STAT_SERIAL_IRQ, 1'b1);
    check(`ADDR_SERIAL_STATUS, 8'h21, 8'h21);
    check(`ADDR_DATA_BUFFER, 8'hFF, 8'h3C);
    check(`ADDR_SERIAL_STATUS, 8'h01, 8'h00);
    wr(`ADDR_SERIAL_STATUS, 8'h78);
    sendEn <= 1'b0;
    stretch <= 1'b0;
    // refusal, then stop with a buffer write inside it
    wr(`ADDR_SEQ_CONTROL, 8'h18);
    repeat (3) @(posedge clk);
    pin(sdaOe, 1'b0);
    pin(sclOe, 1'b1);
    wait_bit(`ADDR_SEQ_CONTROL, `SEQ_ACK_ENABLE_BIT, 1'b0);
    wr(`ADDR_SERIAL_STATUS, 8'h78);
    wr(`ADDR_SEQ_CONTROL, 8'h02);
    wr(`ADDR_DATA_BUFFER, 8'h5A);
    check(`ADDR_SERIAL_STATUS, 8'h40, 8'h40);
    wait_bit(`ADDR_SERIAL_STATUS, `STAT_SERIAL_IRQ, 1'b1);
    check(`ADDR_SERIAL_STATUS, 8'h04, 8'h04);
    check(`ADDR_SEQ_CONTROL, 8'h02, 8'h00);
    pin(sdaLine & sclLine, 1'b1);
    wr(`ADDR_ENGINE_CONTROL, 8'h00);
    check(`ADDR_SERIAL_STATUS, 8'h06, 8'h00);
    // start while another party holds sda low, then that party lets go
    wr(`ADDR_ENGINE_CONTROL, 8'h01);
    tbSda <= 1'b1;
    wr(`ADDR_SEQ_CONTROL, 8'h01);
    wait_bit(`ADDR_SERIAL_STATUS, `STAT_BUS_COLLISION, 1'b1);
    check(`ADDR_SEQ_CONTROL, 8'h01, 8'h00);
    pin(busCollision, 1'b1);
    wr(`ADDR_SERIAL_STATUS, 8'h78);
    tbSda <= 1'b0;
    wait_bit(`ADDR_SERIAL_STATUS, `STAT_SERIAL_IRQ, 1'b1);
    pin(serialIrq, 1'b1);
    check(`ADDR_SERIAL_STATUS, 8'h04, 8'h04);
    // transmit lost at its first bit, a fresh byte, then a reset mid-byte
    wr(`ADDR_SERIAL_STATUS, 8'h78);
    wr(`ADDR_DATA_BUFFER, 8'hFF);
    tbSda <= 1'b1;
    wait_bit(`ADDR_SERIAL_STATUS, `STAT_BUS_COLLISION, 1'b1);
    check(`ADDR_SERIAL_STATUS, 8'h01, 8'h00);
    pin(sdaOe | sclOe, 1'b0);
    tbSda <= 1'b0;
    wr(`ADDR_SERIAL_STATUS, 8'h78);
    wr(`ADDR_DATA_BUFFER, 8'h7F);
    @(posedge clk);
    pin(sdaOe, 1'b1);
    check(`ADDR_SERIAL_STATUS, 8'h41, 8'h01);
    pin(sdaOut | sclOut, 1'b0);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    pin(sdaOe | sclOe, 1'b0);
    check(`ADDR_ENGINE_CONTROL, 8'hFF, 8'h00);
    check(`ADDR_SERIAL_STATUS, 8'hFF, 8'h00);
    wrap_up;
  end
endmodule // i2c_master_rx_ack_stop_arbitration_test
